// File: src/rcg_top.sv
// Reference clock output generator with an AXI4-Lite register slave.
//
// Behaviour
// - Enable bit seven runs or stops generator.
// - Duty codes give 25, 50, 75 percent.
// - Duty code zero holds divided output low.
// - Divider code divides base clock by powers.
// - Lowest divider passes base clock, ignores duty.
//
// Added by the designer: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "rcg_defines.svh"

module rcg_top
  import rcg_pkg::*;
(
  // Clock, reset and clock enable.
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  // Write address channel.
  input  wire logic [3:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  // Write data channel.
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  // Write response channel.
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // Read address channel.
  input  wire logic [3:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  // Read data channel.
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Reference clock output.
  output logic             refclk_out
);

  // Software-visible control register.
  rcg_ctrl_t   ctrl_r;
  // Settings in force for the current output period.
  rcg_ctrl_t   act_r;
  // Generator state and its next value.
  rcg_state_t  st_r;
  rcg_state_t  st_nxt;
  // Position inside the output period, in aclk cycles.
  logic [7:0]  cnt_r;
  // Last count of the period and length of the high phase.
  logic [7:0]  per_m1;
  logic [7:0]  hi_len;
  // Output flip-flop.
  logic        out_r;
  // Captured write address and data.
  logic [3:0]  aw_addr_r;
  logic        aw_got_r;
  logic [7:0]  w_byte_r;
  logic        w_strb0_r;
  logic        w_got_r;
  // Response registers.
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic        rvalid_r;
  logic [1:0]  rresp_r;
  logic [31:0] rdata_r;
  // Write is carried out in this cycle.
  logic        do_wr;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // The base clock is taken as aclk/2, so divide-by-N gives a period of 2N cycles.
  // Sizing in nine bits keeps the 256-cycle period of code seven exact.
  assign per_m1 = 8'((9'h2 << act_r.refclk_div_sel) - 9'h1);

  // High phase length; pass-through keeps the base clock's own half period.
  always_comb begin
    if (act_r.refclk_div_sel == 3'h0) begin
      hi_len = 8'h1;
    end else begin
      // Quarters of a period of 2N cycles, N being at least two here.
      hi_len = 8'({6'h0, act_r.refclk_duty_sel} << (act_r.refclk_div_sel - 3'h1));
    end
  end

  // Next generator state follows the enable bit.
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      RCG_ST_IDLE: begin
        if (ctrl_r.refclk_run) begin
          st_nxt = RCG_ST_RUN;
        end
      end
      RCG_ST_RUN: begin
        if (!ctrl_r.refclk_run) begin
          st_nxt = RCG_ST_IDLE;
        end
      end
      default: begin
        st_nxt = RCG_ST_IDLE;
      end
    endcase
  end

  // State register; ce low freezes it like every other flop.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= RCG_ST_IDLE;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  // Period counter; held at zero while stopped so a start begins a full period.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= 8'h0;
    end else if (ce) begin
      if (st_r != RCG_ST_RUN) begin
        cnt_r <= 8'h0;
      end else if (cnt_r == per_m1) begin
        cnt_r <= 8'h0;
      end else begin
        cnt_r <= cnt_r + 8'h1;
      end
    end
  end

  // Active settings are loaded only while stopped or on the last cycle of a period.
  // This avoids the runt pulse a mid-period divider change would cut.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      act_r <= `RCG_CTRL_RST;
    end else if (ce) begin
      if (st_r != RCG_ST_RUN || cnt_r == per_m1) begin
        act_r <= ctrl_r;
      end
    end
  end

  // Output flop; high while the count is inside the high phase.
  // In a divided period duty code zero gives a zero length, so the output stays low.
  // Clearing the enable stops at once and may shorten the last pulse.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_r <= 1'b0;
    end else if (ce) begin
      if (st_r == RCG_ST_RUN) begin
        out_r <= (cnt_r < hi_len);
      end else begin
        out_r <= 1'b0;
      end
    end
  end

  assign refclk_out = out_r;

  // Ready terms; each channel takes one item, then waits for the response.
  assign awready = ce && !aw_got_r && !bvalid_r;
  assign wready  = ce && !w_got_r && !bvalid_r;
  assign arready = ce && !rvalid_r;
  assign do_wr   = ce && aw_got_r && w_got_r && !bvalid_r;

  // Write address capture.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r  <= 1'b0;
      aw_addr_r <= 4'h0;
    end else if (awvalid && awready) begin
      aw_got_r  <= 1'b1;
      aw_addr_r <= awaddr;
    end else if (do_wr) begin
      aw_got_r  <= 1'b0;
    end
  end

  // Write data capture; only the low byte holds register bits.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_got_r   <= 1'b0;
      w_byte_r  <= 8'h0;
      w_strb0_r <= 1'b0;
    end else if (wvalid && wready) begin
      w_got_r   <= 1'b1;
      w_byte_r  <= wdata[7:0];
      w_strb0_r <= wstrb[0];
    end else if (do_wr) begin
      w_got_r   <= 1'b0;
    end
  end

  // Control register; reserved bits are never stored.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= `RCG_CTRL_RST;
    end else if (do_wr && w_strb0_r && {aw_addr_r[3:2], 2'h0} == `RCG_OFF_CTRL) begin
      ctrl_r.refclk_run      <= w_byte_r[`RCG_RUN_BIT];
      ctrl_r.rsvd            <= 2'h0;
      ctrl_r.refclk_duty_sel <= w_byte_r[`RCG_DUTY_HI:`RCG_DUTY_LO];
      ctrl_r.refclk_div_sel  <= w_byte_r[`RCG_DIV_HI:`RCG_DIV_LO];
    end
  end

  // Write response; only the control register accepts writes.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r  <= `RCG_RESP_OKAY;
    end else if (do_wr) begin
      bvalid_r <= 1'b1;
      if ({aw_addr_r[3:2], 2'h0} == `RCG_OFF_CTRL) begin
        bresp_r <= `RCG_RESP_OKAY;
      end else begin
        bresp_r <= `RCG_RESP_DECERR;
      end
    end else if (ce && bready) begin
      bvalid_r <= 1'b0;
    end
  end

  assign bvalid = bvalid_r;
  assign bresp  = bresp_r;

  // Read channel; status shows the settings in force and the live count.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rresp_r  <= `RCG_RESP_OKAY;
      rdata_r  <= 32'h0;
    end else if (arvalid && arready) begin
      rvalid_r <= 1'b1;
      case ({araddr[3:2], 2'h0})
        `RCG_OFF_CTRL: begin
          rresp_r <= `RCG_RESP_OKAY;
          rdata_r <= {24'h0, ctrl_r};
        end
        `RCG_OFF_STAT: begin
          rresp_r <= `RCG_RESP_OKAY;
          rdata_r <= {8'h0, cnt_r, act_r, 6'h0, (st_r == RCG_ST_RUN), out_r};
        end
        default: begin
          rresp_r <= `RCG_RESP_DECERR;
          rdata_r <= 32'h0;
        end
      endcase
    end else if (ce && rready) begin
      rvalid_r <= 1'b0;
    end
  end

  assign rvalid = rvalid_r;
  assign rresp  = rresp_r;
  assign rdata  = rdata_r;

  // Steps of a running period, used by the checks below.
  sequence s_run;
    ce && st_r == RCG_ST_RUN;
  endsequence
  sequence s_wrap;
    s_run ##0 cnt_r == per_m1;
  endsequence

  // A cleared enable stops the generator and lowers the output within two cycles.
  a_run_gate: assert property (ce && !ctrl_r.refclk_run ##1 ce |=> !refclk_out)
    else $error("output not low after enable cleared");

  // In a divided period the output follows the quarter-period high length.
  a_duty_len: assert property (s_run ##0 act_r.refclk_div_sel != 3'h0 |=>
      refclk_out == ($past(cnt_r) < ({6'h0, $past(act_r.refclk_duty_sel)} << ($past(act_r.refclk_div_sel) - 3'h1))))
    else $error("high time does not match duty code");

  // Duty code zero keeps the divided output low all period.
  a_duty_zero: assert property (s_run ##0 act_r.refclk_div_sel != 3'h0 ##0 act_r.refclk_duty_sel == 2'h0
      |=> !refclk_out)
    else $error("output high with zero duty");

  // The counter wraps after exactly twice the divide ratio.
  a_div_wrap: assert property (s_wrap |=> cnt_r == 8'h0)
    else $error("period counter did not wrap");
  a_div_len: assert property (s_run ##0 cnt_r != per_m1 |=> cnt_r == $past(cnt_r) + 8'h1)
    else $error("period counter skipped");

  // Pass-through toggles every cycle whatever the duty code.
  a_pass_thru: assert property (s_run ##0 act_r.refclk_div_sel == 3'h0 ##0 cnt_r == 8'h0 ##1 ce
      |=> !refclk_out ##0 $past(refclk_out))
    else $error("base clock not passed through");

  // Active settings change only when stopped or at a period end.
  a_bound_apply: assert property (act_r != $past(act_r) |->
      $past(st_r != RCG_ST_RUN || cnt_r == per_m1))
    else $error("settings changed mid-period");

  // A write response stands until the master takes it.
  a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");

endmodule // rcg_top

// File: common/rcg_defines.svh
// Offsets, field positions, reset values and responses of the reference clock generator.
`ifndef RCG_DEFINES_SVH
`define RCG_DEFINES_SVH
// Register byte offsets on the bus.
`define RCG_OFF_CTRL    4'h0
`define RCG_OFF_STAT    4'h4
// Field positions inside the control register.
`define RCG_RUN_BIT     7
`define RCG_DUTY_HI     4
`define RCG_DUTY_LO     3
`define RCG_DIV_HI      2
`define RCG_DIV_LO      0
// Reset value of the control register.
`define RCG_CTRL_RST    8'h00
// Bus responses.
`define RCG_RESP_OKAY   2'h0
`define RCG_RESP_DECERR 2'h3
`endif

// File: common/rcg_pkg.sv
// Types shared by the reference clock generator.
package rcg_pkg;
  // Control register image, laid out as software sees it.
  typedef struct packed {
    logic       refclk_run;      // Generator enable.
    logic [1:0] rsvd;            // Unimplemented, read as zero.
    logic [1:0] refclk_duty_sel; // High time in quarters of a period.
    logic [2:0] refclk_div_sel;  // Power-of-two divide code.
  } rcg_ctrl_t;
  // Generator state, one-hot.
  typedef enum logic [1:0] {
    RCG_ST_IDLE = 2'b01,
    RCG_ST_RUN  = 2'b10
  } rcg_state_t;
endpackage

// File: testbench/rcg_top_tb.sv
// Self-checking testbench for the reference clock generator.
`timescale 1ns/1ps

module rcg_top_tb;
  import rcg_pkg::*;
  // Clock, reset and bus stimulus.
  logic        aclk = 1'b0, aresetn = 1'b0, ce = 1'b1;
  logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
  logic [31:0] wdata = 32'h0, rdata, got;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, refclk_out;
  logic [1:0]  bresp, rresp, resp;
  // Counters and waveform measurements.
  int          mismatches = 0, checked = 0, hi, per, run_len = 0, last_hi = 0;

  rcg_top i_dut (.aclk, .aresetn, .ce, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .refclk_out);

  // Free-running 50 MHz clock.
  initial begin
    forever #10 aclk = ~aclk;
  end

  // Length of the last complete high pulse, so a cut pulse shows up.
  always @(posedge aclk) begin
    if (refclk_out === 1'b1) begin
      run_len <= run_len + 1;
    end else if (run_len != 0) begin
      last_hi <= run_len;
      run_len <= 0;
    end
  end

  // Compares a data value.
  task automatic chk_val(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED t=%0t value %h expected %h", $time, g, e);
    end
  endtask

  // Compares a bus response code.
  task automatic chk_resp(input logic [1:0] g, input logic [1:0] e);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED t=%0t response %h expected %h", $time, g, e);
    end
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic end_sim();
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Write: address and data offered together, each released once taken.
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= s;
    wvalid <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && awready === 1'b1) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    // Raised only now, so a back-to-back call never touches it twice in one step.
    bready <= 1'b1;
    do @(posedge aclk); while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask

  // Read one register word into got and resp.
  task automatic rd(input logic [3:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge aclk); while (rvalid !== 1'b1);
    got = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  // Measures one high time and period from a rising edge; gives hi 0 if the output never rises.
  task automatic measure(output int h, output int p);
    int n;
    h = 0;
    n = 0;
    while (refclk_out !== 1'b0 && n < 600) begin
      @(posedge aclk);
      n++;
    end
    while (refclk_out !== 1'b1 && n < 600) begin
      @(posedge aclk);
      n++;
    end
    while (refclk_out === 1'b1 && n < 600) begin
      @(posedge aclk);
      h++;
      n++;
    end
    p = h;
    while (refclk_out === 1'b0 && n < 600) begin
      @(posedge aclk);
      p++;
      n++;
    end
  endtask

  // Watchdog, far beyond the roughly ten thousand cycles the tests need.
  initial begin
    #1000000;
    mismatches++;
    end_sim();
  end

  // Main sequence.
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd(4'h0);
    chk_val(got, 32'h0);
    chk_val({31'h0, refclk_out}, 32'h0);
    // Reserved bits must read back as zero.
    wr(4'h0, 32'hffff_ff67, 4'hf);
    rd(4'h0);
    chk_val(got, 32'h07);
    // A write with no byte lane leaves the register alone.
    wr(4'h0, 32'h9a, 4'h0);
    chk_resp(resp, 2'h0);
    rd(4'h0);
    chk_val(got, 32'h07);
    // Unmapped read and a write to the read-only place are refused.
    rd(4'h8);
    chk_resp(resp, 2'h3);
    chk_val(got, 32'h0);
    wr(4'h4, 32'h80, 4'hf);
    chk_resp(resp, 2'h3);
    // Every divider and duty code, started from the stopped state.
    for (int dv = 0; dv < 8; dv++) begin
      for (int dc = 0; dc < 4; dc++) begin
        wr(4'h0, 32'h0, 4'hf);
        wr(4'h0, 32'h80 | (dc << 3) | dv, 4'hf);
        rd(4'h0);
        chk_val(got, 32'(32'h80 | (dc << 3) | dv));
        measure(hi, per);
        chk_val(32'(hi), 32'(dv == 0 ? 1 : dc << (dv - 1)));
        if (dv == 0 || dc != 0) begin
          chk_val(32'(per), 32'(2 << dv));
        end
      end
    end
    // Clearing run in mid-pulse stops the output at once.
    wr(4'h0, 32'h07, 4'hf);
    repeat (2) @(posedge aclk);
    chk_val({31'h0, refclk_out}, 32'h0);
    measure(hi, per);
    chk_val(32'(hi), 32'h0);
    // Status while stopped: count zero, settings 0x07 loaded, not running, output low.
    rd(4'h4);
    chk_resp(resp, 2'h0);
    chk_val(got, 32'h0000_0700);
    // A new setting written in mid-pulse waits for the period to end.
    wr(4'h0, 32'h92, 4'hf);
    measure(hi, per);
    wr(4'h0, 32'h91, 4'hf);
    while (refclk_out !== 1'b0) @(posedge aclk);
    @(posedge aclk);
    chk_val(32'(last_hi), 32'h4);
    measure(hi, per);
    chk_val(32'(hi), 32'h2);
    chk_val(32'(per), 32'h4);
    // Clock enable low freezes the divider in the second high cycle and holds the bus off.
    ce <= 1'b0;
    repeat (7) @(posedge aclk);
    chk_val({31'h0, refclk_out}, 32'h1);
    chk_val({31'h0, awready}, 32'h0);
    ce <= 1'b1;
    measure(hi, per);
    chk_val(32'(hi), 32'h2);
    chk_val(32'(per), 32'h4);
    end_sim();
  end
endmodule // rcg_top_tb
